// *** pkg/pot_spi_pkg.sv ***
// Purpose: Shared constants and types for the potentiometer serial command decoder
// Assumes: Serial word is MSB first, 16 bit frame positions numbered 15 down to 0
// Notes:   Reset values of wiper and terminal registers are plain defaults
package pot_spi_pkg;

    // ****************************************************************
    // Widths and counts
    // ****************************************************************
    localparam int          ADDR_W      = 4;
    localparam int          OP_W        = 2;
    localparam int          DATA_W      = 9;
    localparam int          FRAME_W     = 16;
    localparam int          SLOT_COUNT  = 6;
    localparam int          SYNC_W      = 4;

    // ****************************************************************
    // Operation codes
    // ****************************************************************
    localparam logic [1:0]  OP_WRITE    = 2'h0;
    localparam logic [1:0]  OP_INC      = 2'h1;
    localparam logic [1:0]  OP_DEC      = 2'h2;
    localparam logic [1:0]  OP_READ     = 2'h3;

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [3:0]  ADDR_WIPER_0 = 4'h0;
    localparam logic [3:0]  ADDR_WIPER_1 = 4'h1;
    localparam logic [3:0]  ADDR_TCTRL_0 = 4'h4;
    localparam logic [3:0]  ADDR_WIPER_2 = 4'h6;
    localparam logic [3:0]  ADDR_WIPER_3 = 4'h7;
    localparam logic [3:0]  ADDR_TCTRL_1 = 4'ha;

    // ****************************************************************
    // Bit positions within a command (count of bits already taken)
    // ****************************************************************
    localparam logic [3:0]  POS_DECODE  = 4'h5;
    localparam logic [3:0]  POS_FLAG    = 4'h6;
    localparam logic [3:0]  POS_OPBIT   = 4'h7;
    localparam logic [3:0]  POS_BYTE_END = 4'h7;
    localparam logic [3:0]  POS_WORD_END = 4'hf;
    localparam int          WORD_TOP_BIT = 8;

    // ****************************************************************
    // Reset values and limits
    // ****************************************************************
    localparam logic [8:0]  WIPER_RESET     = 9'h000;
    localparam logic [8:0]  TCTRL_RESET     = 9'h000;
    localparam logic [8:0]  FULL_SCALE_8BIT = 9'h100;
    localparam logic [8:0]  FULL_SCALE_7BIT = 9'h080;
    localparam logic [15:0] NV_ADDR_MASK    = 16'h0000;
    localparam logic [3:0]  SYNC_RESET      = 4'h1;

    // ****************************************************************
    // Link state
    // ****************************************************************
    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_LOCKED = 2'b10
    } link_state_t;

endpackage

// *** hw/pot_spi_pin_sync.sv ***
// Purpose: Two flop synchronisers with edge detection for the serial pins
// Assumes: Pins change slower than a few system clock cycles
// Notes:   Edges are seen two clk_in cycles after the pin moves
module pot_spi_pin_sync
#(
    parameter int              WIDTH     = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] rise_out,
    output logic      [WIDTH-1:0] fall_out
);

    // ****************************************************************
    // Per pin chain
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_pin
            logic meta;
            logic stable;
            logic prev;

            // First flop feeds only the second one
            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                begin
                    meta   <= RESET_VAL[i];
                    stable <= RESET_VAL[i];
                    prev   <= RESET_VAL[i];
                end
                else
                begin
                    meta   <= pin_in[i];
                    stable <= meta;
                    prev   <= stable;
                end
            end

            // Edges compare the two settled stages
            assign level_out[i] = stable;
            assign rise_out[i]  = stable & ~prev;
            assign fall_out[i]  = ~stable & prev;
        end
    endgenerate

endmodule // pot_spi_pin_sync

// *** hw/pot_spi_command_decoder.sv ***
// Purpose: Serial command decoder for a quad digital potentiometer register set
// Assumes: clk_in much faster than the serial clock; pins are asynchronous
// Notes:   Serial modes 0,0 and 1,1 both work, data is taken on serial rising edges
//
// Overview of operation
// - Register comes from four address bits, operation from the two bits after.
// - 11 reads, 00 writes, 01 increments wiper, 10 decrements wiper.
// - Increment and decrement are refused on the two terminal registers.
// - Serial output is high for the first six bits of every command.
// - Seventh bit of every command carries the command valid flag.
// - Only listed address and operation pairs are valid; all others are errors.
// - Read and write values are the top command bit plus the data byte.
// - Spare tenth data bit is ignored; its slot carries the valid flag.
// - Valid flag is high for a valid pair and low for an invalid one.
// - A command after a nonvolatile write in the same frame reports invalid.
// - Frames without a whole multiple of eight clocks still run their complete commands; only the partial last one drops.
// - After an error all commands are ignored and output held low.
// - Commands act only when complete; partial ones drop when select ends.
// - Select release resets the interface; only a fresh select restarts it.
// - Any back to back mix of valid commands runs within one frame.
// - Eighth output bit depends on the decoded operation.
// - Elevated select gives the same commands with the same bit counts.
// - A read shifts the nine register bits out in the last nine bits.
// - A write updates its register only after all sixteen bits.
// - Increment stops at full scale and does nothing above it.
module pot_spi_command_decoder
    import pot_spi_pkg::*;
#(
    parameter logic [8:0] FULL_SCALE = FULL_SCALE_8BIT
)
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        cs_n_in,
    input  wire logic        elevated_select_level_in,
    input  wire logic        sck_in,
    input  wire logic        sdi_in,
    output logic             sdo_out,
    output logic             sdo_oe_out,
    output logic             elevated_cmd_out,
    output logic [8:0]       wiper_setting_0_out,
    output logic [8:0]       wiper_setting_1_out,
    output logic [8:0]       wiper_setting_2_out,
    output logic [8:0]       wiper_setting_3_out,
    output logic [8:0]       terminal_connect_ctrl_0_out,
    output logic [8:0]       terminal_connect_ctrl_1_out
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [SYNC_W-1:0]       pin_level;
    logic [SYNC_W-1:0]       pin_rise;
    logic [SYNC_W-1:0]       pin_fall;
    logic                    cs_level_n;
    logic                    cs_start;
    logic                    cs_end;
    logic                    sck_rise;
    logic                    sck_fall;
    logic                    sdi_bit;
    logic                    elevated_level;

    link_state_t             state;
    link_state_t             next_state;
    logic [3:0]              bit_pos;
    logic [3:0]              next_bit_pos;
    logic [FRAME_W-1:0]      shift;
    logic [FRAME_W-1:0]      next_word;
    logic [ADDR_W-1:0]       register_address_field;
    logic [OP_W-1:0]         operation_code_field;
    logic                    command_valid_flag;
    logic                    nv_write_pending;
    logic [DATA_W-1:0]       read_value;
    logic [DATA_W-1:0]       reg_file [SLOT_COUNT];
    logic [DATA_W-1:0]       nine_bit_value;
    logic                    data_top_bit;
    logic                    spare_data_bit;
    logic [ADDR_W-1:0]       decode_addr;
    logic [OP_W-1:0]         decode_op;
    logic                    decode_ok;
    logic                    byte_done;
    logic                    word_done;
    logic                    next_sdo;
    logic [3:0]              read_sel;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    pot_spi_pin_sync
    #(
        .WIDTH     (SYNC_W),
        .RESET_VAL (SYNC_RESET)
    )
    u_pin_sync
    (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .pin_in    ({elevated_select_level_in, sdi_in, sck_in, cs_n_in}),
        .level_out (pin_level),
        .rise_out  (pin_rise),
        .fall_out  (pin_fall)
    );

    // Named views of the synchronised pins
    assign cs_level_n     = pin_level[0];
    assign cs_start       = pin_fall[0];
    assign cs_end         = pin_rise[0];
    assign sck_rise       = pin_rise[1];
    assign sck_fall       = pin_fall[1];
    assign sdi_bit        = pin_level[2];
    assign elevated_level = pin_level[3];

    // ****************************************************************
    // Address decode helpers
    // ****************************************************************
    // Map a register address onto its storage slot
    function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] addr);
        logic [2:0] slot;
        slot = 3'h0;
        case (addr)
            ADDR_WIPER_0: slot = 3'h0;
            ADDR_WIPER_1: slot = 3'h1;
            ADDR_WIPER_2: slot = 3'h2;
            ADDR_WIPER_3: slot = 3'h3;
            ADDR_TCTRL_0: slot = 3'h4;
            ADDR_TCTRL_1: slot = 3'h5;
            default:      slot = 3'h0;
        endcase
        return slot;
    endfunction

    // Legal address and operation pairs
    function automatic logic pair_ok(input logic [ADDR_W-1:0] addr,
                                     input logic [OP_W-1:0]   op);
        logic ok;
        ok = 1'b0;
        case (addr)
            ADDR_WIPER_0,
            ADDR_WIPER_1,
            ADDR_WIPER_2,
            ADDR_WIPER_3: ok = 1'b1;
            ADDR_TCTRL_0,
            ADDR_TCTRL_1: ok = (op == OP_READ) || (op == OP_WRITE);
            default:      ok = 1'b0;
        endcase
        return ok;
    endfunction

    // ****************************************************************
    // Incoming word and field split
    // ****************************************************************
    // Word as it stands once the current bit is taken
    assign next_word = {shift[FRAME_W-2:0], sdi_bit};

    // Address and operation sit in the six newest bits
    assign decode_addr = next_word[5:2];
    assign decode_op   = next_word[1:0];

    // Pending nonvolatile write makes the next command fail
    assign decode_ok = pair_ok(decode_addr, decode_op) && !nv_write_pending;

    // Value built from the top command bit and the data byte
    assign spare_data_bit = next_word[WORD_TOP_BIT+1];
    assign data_top_bit   = next_word[WORD_TOP_BIT];
    assign nine_bit_value = {data_top_bit, next_word[7:0]};

    // Command boundaries: 8 bit for wiper steps, 16 bit otherwise
    assign byte_done = (bit_pos == POS_BYTE_END) &&
                       ((operation_code_field == OP_INC) ||
                        (operation_code_field == OP_DEC));
    assign word_done = (bit_pos == POS_WORD_END);

    // ****************************************************************
    // Link state machine
    // ****************************************************************
    // Only a select fall edge arms the link; the select sync resets high, so a select
    // held low through reset is seen as a fresh select once reset ends
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (cs_start)
                    next_state = ST_ACTIVE;
            end
            ST_ACTIVE:
            begin
                if (cs_level_n)
                    next_state = ST_IDLE;
                else if (sck_rise && (bit_pos == POS_DECODE) && !decode_ok)
                    next_state = ST_LOCKED;
            end
            ST_LOCKED:
            begin
                if (cs_level_n)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // ****************************************************************
    // Bit counter and shift register
    // ****************************************************************
    // Counter wraps at each command boundary so back to back commands line up
    always_comb
    begin
        next_bit_pos = bit_pos + 4'h1;
        if (byte_done || word_done)
            next_bit_pos = 4'h0;
    end

    // Counter clears on select so stray clocks never accumulate
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            bit_pos <= 4'h0;
            shift   <= '0;
        end
        else if (cs_start || cs_level_n)
        begin
            bit_pos <= 4'h0;
            shift   <= '0;
        end
        else if (state == ST_ACTIVE && sck_rise)
        begin
            bit_pos <= next_bit_pos;
            shift   <= next_word;
        end
    end

    // ****************************************************************
    // Decoded command latch
    // ****************************************************************
    // Captured on the sixth bit; read data is frozen here as well
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            register_address_field <= '0;
            operation_code_field   <= OP_WRITE;
            command_valid_flag     <= 1'b1;
            read_value             <= '0;
        end
        else if (cs_start)
        begin
            command_valid_flag     <= 1'b1;
        end
        else if (state == ST_ACTIVE && sck_rise && bit_pos == POS_DECODE)
        begin
            register_address_field <= decode_addr;
            operation_code_field   <= decode_op;
            command_valid_flag     <= decode_ok;
            read_value             <= reg_file[slot_of(decode_addr)];
        end
    end

    // ****************************************************************
    // Nonvolatile write tracking
    // ****************************************************************
    // All present addresses are volatile; the mask keeps the hook ready
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            nv_write_pending <= 1'b0;
        else if (cs_level_n)
            nv_write_pending <= 1'b0;
        else if (state == ST_ACTIVE && sck_rise && word_done &&
                 operation_code_field == OP_WRITE &&
                 NV_ADDR_MASK[register_address_field])
            nv_write_pending <= 1'b1;
    end

    // ****************************************************************
    // Register file updates
    // ****************************************************************
    // Only complete commands act, so a command cut short changes nothing
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            for (int s = 0; s < SLOT_COUNT; s++)
                reg_file[s] <= (s < 4) ? WIPER_RESET : TCTRL_RESET;
        end
        else if (state == ST_ACTIVE && !cs_level_n && sck_rise)
        begin
            if (word_done && operation_code_field == OP_WRITE)
            begin
                reg_file[slot_of(register_address_field)] <= nine_bit_value;
            end
            else if (byte_done && operation_code_field == OP_INC)
            begin
                if (reg_file[slot_of(register_address_field)] < FULL_SCALE)
                    reg_file[slot_of(register_address_field)] <=
                        reg_file[slot_of(register_address_field)] + 9'h001;
            end
            else if (byte_done && operation_code_field == OP_DEC)
            begin
                if (reg_file[slot_of(register_address_field)] != 9'h000 &&
                    reg_file[slot_of(register_address_field)] <= FULL_SCALE)
                    reg_file[slot_of(register_address_field)] <=
                        reg_file[slot_of(register_address_field)] - 9'h001;
            end
        end
    end

    // ****************************************************************
    // Serial output value
    // ****************************************************************
    // Select index of the read bit for positions seven to fifteen
    assign read_sel = POS_WORD_END - bit_pos;

    // Value for the bit slot that the counter now points at
    always_comb
    begin
        next_sdo = 1'b1;
        if (state != ST_ACTIVE)
            next_sdo = 1'b0;
        else if (bit_pos < POS_FLAG)
            next_sdo = 1'b1;
        else if (bit_pos == POS_FLAG)
            next_sdo = command_valid_flag;
        else if (operation_code_field == OP_READ)
            next_sdo = read_value[read_sel];
        else
            next_sdo = 1'b1;
    end

    // ****************************************************************
    // Serial output pin
    // ****************************************************************
    // In an active frame changes only on falling serial edges so the master samples a
    // settled bit on the rising edge; select, release and lock set it directly
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sdo_out    <= 1'b0;
            sdo_oe_out <= 1'b0;
        end
        else if (cs_start && state == ST_IDLE)
        begin
            sdo_out    <= 1'b1;
            sdo_oe_out <= 1'b1;
        end
        else if (cs_level_n)
        begin
            sdo_out    <= 1'b0;
            sdo_oe_out <= 1'b0;
        end
        else if (state == ST_LOCKED)
        begin
            sdo_out    <= 1'b0;
        end
        else if (state == ST_ACTIVE && sck_fall)
        begin
            sdo_out    <= next_sdo;
        end
    end

    // ****************************************************************
    // Elevated select capture
    // ****************************************************************
    // Sampled at select, the commands behave the same either way
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            elevated_cmd_out <= 1'b0;
        else if (cs_start && state == ST_IDLE)
            elevated_cmd_out <= elevated_level;
        else if (cs_end)
            elevated_cmd_out <= 1'b0;
    end

    // ****************************************************************
    // Register outputs
    // ****************************************************************
    // Straight from the storage flops
    assign wiper_setting_0_out         = reg_file[0];
    assign wiper_setting_1_out         = reg_file[1];
    assign wiper_setting_2_out         = reg_file[2];
    assign wiper_setting_3_out         = reg_file[3];
    assign terminal_connect_ctrl_0_out = reg_file[4];
    assign terminal_connect_ctrl_1_out = reg_file[5];

endmodule // pot_spi_command_decoder

// *** bench/pot_spi_master.sv ***
// Purpose: SPI master stand-in for the decoder, mode 0,0, MSB first
// Assumes: Half serial period of four clk_in cycles (160 ns link)
// Notes:   Clock parks low outside frames, data line toggles on release
module pot_spi_master
(
    input  wire logic clk_in,
    input  wire logic sdo_in,
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      sdi_out,
    output logic      elev_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cs_n_out, sck_out, sdi_out, elev_out} = 4'h8;
    // Pins always move a fixed step after a clk_in edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    // Fresh select; level choice held for the whole frame
    task automatic start(input logic hv);
        elev_out = hv;
        cs_n_out = 1'b0;
        tick(10);
    endtask
    // Release; stale data is not left on the line
    task automatic stop();
        tick(2);
        cs_n_out = 1'b1;
        sdi_out  = ~sdi_out;
        tick(10);
    endtask
    // sdo lags the fall by the sync delay, so read it late in the high phase
    task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi_out = w[i];
            tick(4);
            sck_out = 1'b1;
            tick(3);
            rx = {rx[14:0], sdo_in};
            tick(1);
            sck_out = 1'b0;
        end
    endtask
endmodule // pot_spi_master

// *** bench/pot_spi_checker.sv ***
// Purpose: Pin timing checks for the decoder
// Assumes: Serial half period well above the pin sync delay
// Notes:   Bound to every decoder instance
module pot_spi_checker
(
    input wire logic       clk_in,
    input wire logic       resetn_in,
    input wire logic       cs_n_in,
    input wire logic       elevated_select_level_in,
    input wire logic       sck_in,
    input wire logic       sdo_out,
    input wire logic       sdo_oe_out,
    input wire logic       elevated_cmd_out,
    input wire logic [8:0] wiper_setting_0_out,
    input wire logic [8:0] wiper_setting_1_out,
    input wire logic [8:0] wiper_setting_2_out,
    input wire logic [8:0] wiper_setting_3_out,
    input wire logic [8:0] terminal_connect_ctrl_0_out,
    input wire logic [8:0] terminal_connect_ctrl_1_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [53:0] regs = {wiper_setting_0_out, wiper_setting_1_out, wiper_setting_2_out,
        wiper_setting_3_out, terminal_connect_ctrl_0_out, terminal_connect_ctrl_1_out};
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // Deselected: six cycles covers the two flop sync plus output flop
    a_oe_idle_off: assert property (cs_n_in [*6] |-> !sdo_oe_out)
        else $error("sdo enabled while deselected");
    a_regs_idle: assert property (cs_n_in [*6] |-> $stable(regs))
        else $error("register moved while deselected");
    a_elev_clear: assert property (cs_n_in [*6] |-> !elevated_cmd_out)
        else $error("elevated flag left set");
    a_oe_hold: assert property (sdo_oe_out && !cs_n_in |=> sdo_oe_out)
        else $error("sdo enable dropped inside frame");
    // Fresh select
    a_oe_on_select: assert property ($fell(cs_n_in) |-> ##6 sdo_oe_out)
        else $error("sdo not enabled after select");
    a_sdo_first_high: assert property ($fell(cs_n_in) |-> ##6 sdo_out)
        else $error("sdo low before first bit");
    a_elev_take:
        assert property ($fell(cs_n_in) |-> ##6 elevated_cmd_out == elevated_select_level_in)
        else $error("elevated level not captured");
    a_regs_on_rise:
        assert property (!$stable(regs) |-> !cs_n_in && ($past(sck_in, 2) || $past(sck_in, 4)))
        else $error("register moved away from a serial rise");
    c_elev: cover property (sdo_oe_out && elevated_cmd_out);
    c_update: cover property (!$stable(regs));
    c_low: cover property (sdo_oe_out && !sdo_out);
endmodule // pot_spi_checker

bind pot_spi_command_decoder pot_spi_checker chk (.clk_in, .resetn_in, .cs_n_in,
    .elevated_select_level_in, .sck_in, .sdo_out, .sdo_oe_out, .elevated_cmd_out,
    .wiper_setting_0_out, .wiper_setting_1_out, .wiper_setting_2_out, .wiper_setting_3_out,
    .terminal_connect_ctrl_0_out, .terminal_connect_ctrl_1_out);

// *** bench/testbench.sv ***
// Purpose: Self checking bench for the decoder
// Assumes: Master model at a 160 ns serial period
// Notes:   Model registers track every accepted command
module testbench
    import pot_spi_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in, resetn_in, cs_n, sck, sdi, elev, sdo, lock;
    logic [8:0]  q [6];
    logic [8:0]  m [16];
    logic [15:0] rx;
    logic [3:0]  amap [6] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'ha};
    logic [8:0]  corner [4] = '{9'h000, 9'h0ff, 9'h100, 9'h1ff};
    int          err_total, n_tests;
    pot_spi_master master (.clk_in, .sdo_in(sdo), .cs_n_out(cs_n), .sck_out(sck),
        .sdi_out(sdi), .elev_out(elev));
    pot_spi_command_decoder dut (.clk_in, .resetn_in, .cs_n_in(cs_n),
        .elevated_select_level_in(elev), .sck_in(sck), .sdi_in(sdi), .sdo_out(sdo),
        .sdo_oe_out(), .elevated_cmd_out(), .wiper_setting_0_out(q[0]),
        .wiper_setting_1_out(q[1]), .terminal_connect_ctrl_0_out(q[2]),
        .wiper_setting_2_out(q[3]), .wiper_setting_3_out(q[4]),
        .terminal_connect_ctrl_1_out(q[5]));
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    function automatic logic ok(logic [3:0] a, logic [1:0] op);
        return a inside {4'h0, 4'h1, 4'h6, 4'h7} || (a inside {4'h4, 4'ha} && op inside {2'h0, 2'h3});
    endfunction
    function automatic logic [8:0] nxt(logic [1:0] op, logic [8:0] c, logic [8:0] d);
        if (op == OP_WRITE) return d;
        if (op == OP_INC) return (c < FULL_SCALE_8BIT) ? c + 9'h001 : c;
        if (op == OP_DEC) return (c != 9'h000 && c <= FULL_SCALE_8BIT) ? c - 9'h001 : c;
        return c;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic regs();
        foreach (q[i]) chk({7'h00, q[i]}, {7'h00, m[amap[i]]});
    endtask
    // One command; after an error the frame stays locked
    task automatic cmd(input logic [3:0] a, input logic [1:0] op, input logic [8:0] d);
        logic [15:0] e;
        int          n;
        n = op inside {OP_INC, OP_DEC} ? 8 : 16;
        master.xfer(n, n == 8 ? {8'h00, a, op, 2'($urandom)} : {a, op, 1'($urandom), d}, rx);
        if (lock) e = '0;
        else if (!ok(a, op)) e = 16'hfc00 >> (16 - n);
        else if (op == OP_READ) e = {7'h7f, m[a]};
        else e = 16'hffff >> (16 - n);
        chk(rx, e);
        if (!lock && ok(a, op)) m[a] = nxt(op, m[a], d);
        lock = lock || !ok(a, op);
    endtask
    task automatic final_report();
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #1500000;
        err_total++;
        final_report();
    end
    initial
    begin
        int cut;
        resetn_in = 1'b0;
        err_total = 0;
        n_tests = 0;
        foreach (m[i]) m[i] = WIPER_RESET;
        void'($urandom(6682));
        repeat (3) @(posedge clk_in);
        #2 resetn_in = 1'b1;
        regs();
        // First sixteen frames walk every address with read, write, inc, dec
        for (int f = 0; f < 40; f++)
        begin
            master.start(1'($urandom));
            lock = 1'b0;
            for (int j = 0; j < 4; j++)
                cmd(f < 16 ? 4'(f) : amap[$urandom_range(5)],
                    f < 16 ? 2'(j == 0 ? 3 : j - 1) : 2'($urandom),
                    $urandom_range(1) ? corner[$urandom_range(3)] : 9'($urandom));
            master.stop();
            regs();
        end
        // Cut short write must leave every register alone
        // Top bits go first, so the cut command is always a write that never completes
        master.start(1'b0);
        cut = $urandom_range(15, 1);
        master.xfer(cut, {amap[$urandom_range(5)], OP_WRITE, 10'($urandom)} >> (16 - cut),
            rx);
        chk(rx, 16'hffff >> (16 - cut));
        master.stop();
        regs();
        final_report();
    end
endmodule // testbench
